// File: logic/rcgr_pkg.sv
// Constants and carrier types for the range configuration and group refresh block
package rcgr_pkg;

  // Bus addressing and command codes
  localparam logic [7:0]  RCGR_GC_ADDR        = 8'h00;
  localparam logic [6:0]  RCGR_OWN_ADDR_DEF   = 7'h10;
  localparam logic [7:0]  RCGR_CMD_GROUP_REF  = 8'h1E;
  localparam logic [7:0]  RCGR_CMD_RANGE_CFG  = 8'h1D;

  // Range register layout and reset value
  localparam logic [15:0] RCGR_RANGE_RESET    = 16'h0000;
  localparam logic [1:0]  RCGR_RANGE_UNI      = 2'h0;
  localparam logic [1:0]  RCGR_RANGE_BI       = 2'h1;
  localparam int          RCGR_SENSE_TOP      = 15;
  localparam int          RCGR_BUS_TOP        = 7;
  localparam int          RCGR_CHANNELS       = 4;

  // Byte framing
  localparam logic [3:0]  RCGR_BITS_PER_BYTE  = 4'h8;

  // Settling delay after a refresh
  localparam int          RCGR_SETTLE_US      = 1000;
  localparam int          RCGR_CLK_MHZ        = 20;
  localparam int          RCGR_SETTLE_CYC     = RCGR_SETTLE_US * RCGR_CLK_MHZ;
  localparam int          RCGR_SETTLE_W       = 15;

  typedef enum logic [2:0] {
    RCGR_ST_IDLE,
    RCGR_ST_ADDR,
    RCGR_ST_CMD,
    RCGR_ST_WDATA,
    RCGR_ST_RDATA
  } rcgr_state_t;

  // Live results from the measurement path, and their readable copy
  typedef struct packed {
    logic [3:0][31:0] accum_value;
    logic [31:0]      accum_count;
    logic [3:0][15:0] bus_voltage;
    logic [3:0][15:0] sense_voltage;
  } rcgr_meas_t;

endpackage : rcgr_pkg

// File: logic/rcgr_top.sv
// Range polarity register and group refresh command behind a two-wire slave port
//
// Contract
// - Sense range fields: 00 unipolar, 01 bipolar
// - Bus range fields: 00 unipolar, 01 bipolar
// - Group refresh is command byte, no data
// - Group refresh accepted via general call
// - Refresh copies accumulators and voltages to snapshot
// - Refresh clears internal accumulators after copying
// - Snapshot stable until next refresh
`timescale 1ns/1ps
module rcgr_top
  import rcgr_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR      = RCGR_OWN_ADDR_DEF,
  parameter int         SETTLE_CYCLES = RCGR_SETTLE_CYC
) (
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output wire logic                     sda_out,
  output wire logic                     sda_oe_n,
  input  wire rcgr_meas_t               meas_in,
  output rcgr_meas_t                    snap,
  output wire logic                     accum_clear,
  output wire logic                     results_ready,
  output logic [15:0]                   range_cfg,
  output logic [RCGR_CHANNELS-1:0]      sense_bipolar,
  output logic [RCGR_CHANNELS-1:0]      bus_bipolar
);

  logic                     scl_s1_r, scl_s2_r, scl_s3_r;
  logic                     sda_s1_r, sda_s2_r, sda_s3_r;
  rcgr_state_t              state_r;
  logic [3:0]               cnt_r;
  logic [7:0]               sh_r;
  logic [7:0]               tx_r;
  logic [7:0]               ptr_r;
  logic [7:0]               hold_r;
  logic                     ack_r;
  logic                     drive_r;
  logic                     gc_r;
  logic                     nack_r;
  logic                     byte_idx_r;
  logic                     refresh_r;
  logic [RCGR_SETTLE_W-1:0] settle_r;
  logic                     results_ready_r;
  logic [15:0]              range_cfg_r;
  rcgr_meas_t               snap_r;

  // Pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  wire logic scl_rise  = scl_s2_r & ~scl_s3_r;
  wire logic scl_fall  = ~scl_s2_r & scl_s3_r;
  wire logic start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  wire logic stop_det  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
  wire logic byte_done = scl_fall & ~ack_r & (cnt_r == RCGR_BITS_PER_BYTE);
  wire logic addr_hit  = (sh_r[7:1] == OWN_ADDR) || (sh_r == RCGR_GC_ADDR);
  wire logic range_sel = (ptr_r == RCGR_CMD_RANGE_CFG);
  // Either address path lands here alike
  wire logic refresh_hit = byte_done && (state_r == RCGR_ST_CMD)
                           && (sh_r == RCGR_CMD_GROUP_REF);
  wire logic range_we  = byte_done && (state_r == RCGR_ST_WDATA) && !gc_r && range_sel && byte_idx_r;
  wire logic [15:0] range_wdata = {hold_r, sh_r};
  wire logic [7:0]  rd_byte = range_sel ? (byte_idx_r ? range_cfg_r[7:0] : range_cfg_r[15:8]) : 8'h00;

  // Open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r    <= RCGR_ST_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= 8'h00;
      hold_r     <= 8'h00;
      ack_r      <= 1'b0;
      drive_r    <= 1'b0;
      gc_r       <= 1'b0;
      nack_r     <= 1'b0;
      byte_idx_r <= 1'b0;
    end else if (start_det) begin
      state_r <= RCGR_ST_ADDR;
      cnt_r   <= 4'h0;
      ack_r   <= 1'b0;
      drive_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= RCGR_ST_IDLE;
      ack_r   <= 1'b0;
      drive_r <= 1'b0;
    end else if (state_r != RCGR_ST_IDLE) begin
      if (scl_rise) begin
        if (ack_r) begin
          nack_r <= sda_s2_r;
        end else begin
          sh_r  <= {sh_r[6:0], sda_s2_r};
          cnt_r <= cnt_r + 4'h1;
        end
      end
      if (scl_fall) begin
        if (ack_r) begin
          ack_r <= 1'b0;
          cnt_r <= 4'h0;
          if (state_r == RCGR_ST_RDATA && !nack_r) begin
            tx_r    <= rd_byte;
            drive_r <= ~rd_byte[7];
          end else if (state_r == RCGR_ST_RDATA) begin
            state_r <= RCGR_ST_IDLE;
            drive_r <= 1'b0;
          end else begin
            drive_r <= 1'b0;
          end
        end else if (cnt_r == RCGR_BITS_PER_BYTE) begin
          ack_r <= 1'b1;
          case (state_r)
            RCGR_ST_ADDR: begin
              if (addr_hit) begin
                drive_r    <= 1'b1;
                gc_r       <= (sh_r == RCGR_GC_ADDR);
                byte_idx_r <= 1'b0;
                state_r    <= sh_r[0] ? RCGR_ST_RDATA : RCGR_ST_CMD;
              end else begin
                state_r <= RCGR_ST_IDLE;
                drive_r <= 1'b0;
              end
            end
            RCGR_ST_CMD: begin
              ptr_r      <= sh_r;
              byte_idx_r <= 1'b0;
              // General call carries nothing but the group refresh
              if (gc_r && sh_r != RCGR_CMD_GROUP_REF) begin
                state_r <= RCGR_ST_IDLE;
                drive_r <= 1'b0;
              end else begin
                state_r <= RCGR_ST_WDATA;
                drive_r <= 1'b1;
              end
            end
            RCGR_ST_WDATA: begin
              if (!gc_r && range_sel) begin
                drive_r    <= 1'b1;
                hold_r     <= sh_r;
                byte_idx_r <= ~byte_idx_r;
              end else begin
                state_r <= RCGR_ST_IDLE;
                drive_r <= 1'b0;
              end
            end
            RCGR_ST_RDATA: begin
              drive_r    <= 1'b0;
              byte_idx_r <= ~byte_idx_r;
            end
            default: begin
              state_r <= RCGR_ST_IDLE;
              drive_r <= 1'b0;
            end
          endcase
        end else if (state_r == RCGR_ST_RDATA) begin
          tx_r    <= {tx_r[6:0], 1'b0};
          drive_r <= ~tx_r[6];
        end
      end
    end
  end

  // Whole word stored, reserved codes included
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      range_cfg_r <= RCGR_RANGE_RESET;
    end else if (range_we) begin
      range_cfg_r <= range_wdata;
    end
  end

  assign range_cfg = range_cfg_r;

  wire logic [RCGR_CHANNELS-1:0] sense_bipolar_nxt;
  wire logic [RCGR_CHANNELS-1:0] bus_bipolar_nxt;
  logic      [RCGR_CHANNELS-1:0] sense_bipolar_r;
  logic      [RCGR_CHANNELS-1:0] bus_bipolar_r;

  genvar ch;
  generate
    for (ch = 0; ch < RCGR_CHANNELS; ch++) begin : g_dec
      assign sense_bipolar_nxt[ch] = range_cfg_r[RCGR_SENSE_TOP-2*ch -: 2] == RCGR_RANGE_BI;
      assign bus_bipolar_nxt[ch]   = range_cfg_r[RCGR_BUS_TOP-2*ch -: 2] == RCGR_RANGE_BI;
    end
  endgenerate
  // Registered decode trails the range word by one clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sense_bipolar_r <= '0;
      bus_bipolar_r   <= '0;
    end else begin
      sense_bipolar_r <= sense_bipolar_nxt;
      bus_bipolar_r   <= bus_bipolar_nxt;
    end
  end

  assign sense_bipolar = sense_bipolar_r;
  assign bus_bipolar   = bus_bipolar_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      refresh_r <= 1'b0;
    end else begin
      refresh_r <= refresh_hit;
    end
  end

  // Copy takes the pre-clear value; accumulators zero on the same edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      snap_r <= '0;
    end else if (refresh_r) begin
      snap_r <= meas_in;
    end
  end

  assign snap        = snap_r;
  assign accum_clear = refresh_r;

  // Ready flag lets the host avoid a blind 1 ms wait
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      settle_r        <= '0;
      results_ready_r <= 1'b1;
    end else if (refresh_r) begin
      settle_r        <= RCGR_SETTLE_W'(SETTLE_CYCLES);
      results_ready_r <= 1'b0;
    end else begin
      // Rises on the edge the counter empties
      results_ready_r <= (settle_r[RCGR_SETTLE_W-1:1] == '0);
      if (settle_r != '0) begin
        settle_r <= settle_r - 1'b1;
      end
    end
  end

  assign results_ready = results_ready_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_sense_reset: assert property ($past(sys_rst) |-> range_cfg_r[15:8] == 8'h00 && sense_bipolar == 4'h0)
    else $error("sense range not unipolar after reset");
  chk_bus_reset: assert property ($past(sys_rst) |-> range_cfg_r[7:0] == 8'h00 && bus_bipolar == 4'h0)
    else $error("bus range not unipolar after reset");
  chk_cmd_fires: assert property (refresh_hit |=> refresh_r ##1 !refresh_r)
    else $error("group refresh not a single pulse after command");
  chk_gc_accept: assert property (byte_done && state_r == RCGR_ST_CMD && gc_r && sh_r == RCGR_CMD_GROUP_REF
                                  |-> ##1 accum_clear)
    else $error("general call refresh ignored");
  chk_snap_copy: assert property (refresh_r |=> snap_r == $past(meas_in))
    else $error("snapshot does not match live results");
  chk_accum_clear: assert property (accum_clear |-> $past(refresh_hit) ##1 !accum_clear)
    else $error("accumulator clear without command");
  chk_snap_hold: assert property (!refresh_r |=> $stable(snap_r))
    else $error("snapshot changed without refresh");
  chk_settle_wait: assert property (refresh_r |=> !results_ready [*8])
    else $error("results ready too early");
  chk_reserved_keep: assert property (range_we |=> range_cfg_r == $past(range_wdata))
    else $error("range word not stored as written");
  chk_gc_same: assert property (refresh_r |-> $past(state_r) == RCGR_ST_CMD
                                && $past(sh_r) == RCGR_CMD_GROUP_REF)
    else $error("refresh from unexpected path");

  cov_gc_refresh: cover property (refresh_r && gc_r);
  cov_own_refresh: cover property (refresh_r && !gc_r);
  cov_range_write: cover property (range_we && range_wdata[15:14] == RCGR_RANGE_BI);
  cov_range_read: cover property (state_r == RCGR_ST_RDATA && byte_idx_r);

endmodule : rcgr_top

// File: dv/rcgr_host.sv
// Two-wire bus host model for the slave port
`timescale 1ns/1ps
module rcgr_host (
  input  wire logic ref_clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Four clocks a half period: 400 ns link clock
  task automatic hc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : hc
  task automatic start();
    sda_low = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_low = 1'b1;
    hc(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    hc(1);
    sda_low = 1'b1;
    hc(3);
    scl = 1'b1;
    hc(4);
    sda_low = 1'b0;
    hc(8);
  endtask : stop
  // Data moves one clock after SCL falls, never beside an SCL edge
  task automatic bit_x(input logic b, output logic r);
    hc(1);
    sda_low = !b;
    hc(3);
    scl = 1'b1;
    hc(3);
    r = sda_line;
    hc(1);
    scl = 1'b0;
  endtask : bit_x
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask : rbyte
endmodule : rcgr_host

// File: dv/tb_rcgr_top.sv
// Self-checking bench for range register and group refresh
`timescale 1ns/1ps
module tb_rcgr_top;
  import rcgr_pkg::*;
  localparam int          SETTLE = 16;
  localparam logic [7:0]  OWN_W  = {RCGR_OWN_ADDR_DEF, 1'b0};
  localparam logic [15:0] PAT[2] = '{16'h4E1B, 16'h5555};
  localparam logic [7:0]  DEC[2] = '{8'h12, 8'hFF};
  logic        ref_clk, sys_rst, scl, sda_low, sda_out, sda_oe_n, accum_clear, results_ready, ack, ack2;
  logic [15:0] range_cfg;
  logic [3:0]  sense_bi, bus_bi;
  logic [7:0]  hi, lo;
  rcgr_meas_t  meas, snap;
  int          fails, n_tests, n_clr, n_low, c0, l0, cyc;
  wire logic   sda_line = !(sda_low || (!sda_oe_n && !sda_out));
  rcgr_host u_host (.ref_clk(ref_clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));
  rcgr_top #(.SETTLE_CYCLES(SETTLE)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .meas_in(meas), .snap(snap),
    .accum_clear(accum_clear), .results_ready(results_ready), .range_cfg(range_cfg),
    .sense_bipolar(sense_bi), .bus_bipolar(bus_bi));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Run needs about 3000 clocks; ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cyc++;
    if (results_ready === 1'b0) n_low++;
    if (accum_clear === 1'b1) n_clr++;
    if (cyc == 12000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp
  task automatic cmp_meas(input rcgr_meas_t got, input rcgr_meas_t exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t snapshot mismatch", $time);
    end
  endtask : cmp_meas
  task automatic conclude();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic send(input logic [7:0] a, input logic [7:0] c, input logic extra);
    u_host.start();
    u_host.wbyte(a, ack);
    u_host.wbyte(c, ack);
    ack2 = 1'b0;
    if (extra) u_host.wbyte(8'h3C, ack2);
    u_host.stop();
  endtask : send
  initial begin
    sys_rst = 1'b1;
    meas = '0;
    repeat (20) @(posedge ref_clk);
    #2 sys_rst = 1'b0;
    u_host.hc(4);
    cmp(range_cfg, RCGR_RANGE_RESET, "range reset");
    cmp({8'h00, sense_bi, bus_bi}, 16'h0000, "unipolar reset");
    $display("test reset done");
    // Reserved codes 10 and 11 ride in the first pattern
    for (int i = 0; i < 2; i++) begin
      send(OWN_W, RCGR_CMD_RANGE_CFG, 1'b0);
      u_host.start();
      u_host.wbyte(OWN_W, ack);
      u_host.wbyte(RCGR_CMD_RANGE_CFG, ack);
      u_host.wbyte(PAT[i][15:8], ack);
      u_host.wbyte(PAT[i][7:0], ack);
      u_host.stop();
      cmp(range_cfg, PAT[i], "range stored");
      cmp({8'h00, sense_bi, bus_bi}, {8'h00, DEC[i]}, "range decode");
      u_host.start();
      u_host.wbyte(OWN_W, ack);
      u_host.wbyte(RCGR_CMD_RANGE_CFG, ack);
      u_host.start();
      u_host.wbyte(OWN_W | 8'h01, ack);
      u_host.rbyte(1'b0, hi);
      u_host.rbyte(1'b1, lo);
      u_host.stop();
      cmp({hi, lo}, PAT[i], "range readback");
    end
    $display("test range done");
    for (int k = 0; k < 2; k++) begin
      meas = {9{k ? 32'hA5C3_0F1E : 32'h0123_4567}};
      c0 = n_clr;
      l0 = n_low;
      send(k ? OWN_W : RCGR_GC_ADDR, RCGR_CMD_GROUP_REF, 1'b0);
      u_host.hc(SETTLE);
      cmp({15'h0, ack}, 16'h0001, "refresh ack");
      cmp(16'(n_clr - c0), 16'h0001, "clear pulse");
      cmp(16'(n_low - l0), 16'(SETTLE), "settle time");
      cmp_meas(snap, meas);
      meas = ~meas;
      u_host.hc(8);
      cmp_meas(snap, ~meas);
    end
    $display("test refresh done");
    c0 = n_clr;
    send(RCGR_GC_ADDR, RCGR_CMD_RANGE_CFG, 1'b0);
    cmp({15'h0, ack}, 16'h0000, "general call other command");
    send(8'h44, RCGR_CMD_GROUP_REF, 1'b0);
    cmp({15'h0, ack}, 16'h0000, "foreign address");
    send(OWN_W, RCGR_CMD_GROUP_REF, 1'b1);
    cmp({15'h0, ack2}, 16'h0000, "data after refresh");
    cmp(16'(n_clr - c0), 16'h0001, "single clear");
    u_host.start();
    u_host.wbyte(OWN_W | 8'h01, ack);
    u_host.rbyte(1'b1, hi);
    u_host.stop();
    cmp({8'h00, hi}, 16'h0000, "other pointer read");
    $display("test refusal done");
    conclude();
  end
endmodule : tb_rcgr_top
